// ### isv_defines.svh
`ifndef ISV_DEFINES_SVH
`define ISV_DEFINES_SVH

// Fixed vector entries, 20-bit addresses
`define ISV_VEC_UND 20'hFFFDC
`define ISV_VEC_OVF 20'hFFFE0
`define ISV_VEC_BRK 20'hFFFE4
`define ISV_VEC_AMATCH 20'hFFFE8
`define ISV_VEC_STEP 20'hFFFEC
`define ISV_VEC_WDT 20'hFFFF0
`define ISV_VEC_DBG 20'hFFFF4
`define ISV_VEC_NMI 20'hFFFF8
`define ISV_VEC_RESET 20'hFFFFC
// Break entry value that redirects to the relocatable table
`define ISV_BRK_REDIRECT 8'hFF
// Relocatable entry numbers of the break redirect and the pin-driven sources
`define ISV_NUM_BRK 6'h00
`define ISV_NUM_KEY 5'h0D
`define ISV_NUM_EXT3 5'h04
`define ISV_NUM_EXT4 5'h18
`define ISV_NUM_EXT5 5'h19
`define ISV_NUM_EXT0 5'h1D
`define ISV_NUM_EXT1 5'h1E
`define ISV_NUM_EXT2 5'h1F
// Edge select encodings for external pins
`define ISV_EDGE_FALL 2'h0
`define ISV_EDGE_RISE 2'h1
`define ISV_EDGE_BOTH 2'h2
`endif

// ### isv_pkg.sv
package isv_pkg;
  // Acceptance sequencer, Gray along idle-fetch-relocate-branch
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_RELOC = 2'b11,
    ST_BRANCH = 2'b10
  } isv_state_type;
  // Source being served
  typedef enum logic [3:0] {
    SRC_RESET = 4'h0,
    SRC_UND = 4'h1,
    SRC_OVF = 4'h2,
    SRC_BRK = 4'h3,
    SRC_TRAP = 4'h4,
    SRC_NMI = 4'h5,
    SRC_DBG = 4'h6,
    SRC_WDT = 4'h7,
    SRC_STEP = 4'h8,
    SRC_AMATCH = 4'h9,
    SRC_PERIPH = 4'hA,
    SRC_NONE = 4'hF
  } isv_src_type;
endpackage

// ### isv_edge_sync.sv
`include "isv_defines.svh"
module isv_edge_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] rise_en_i,
  input wire logic [WIDTH-1:0] fall_en_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] edge_o
);
  import isv_pkg::*;
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] stable_q;
  logic [WIDTH-1:0] edge_q;

  if (WIDTH < 1) begin : g_chk
    $error("isv_edge_sync needs WIDTH of at least 1");
  end

  // Three-stage synchroniser; reset high since the pins idle high
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a new level only when stages two and three agree, filtering single glitches
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        stable_q[b] <= 1'b1;
        edge_q[b] <= 1'b0;
      end else begin
        if (s2_q[b] == s3_q[b]) begin
          stable_q[b] <= s3_q[b];
        end
        edge_q[b] <= (s2_q[b] == s3_q[b]) && (s3_q[b] != stable_q[b]) &&
                     (s3_q[b] ? rise_en_i[b] : fall_en_i[b]);
      end
    end
  end

  assign level_o = stable_q;
  assign edge_o = edge_q;
endmodule

// ### isv_ctrl.sv
`include "isv_defines.svh"
module isv_ctrl #(
  parameter int NUM_SRC = 32,
  parameter int KEY_WIDTH = 8,
  parameter int NEST_DEPTH = 8
) (
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  // Core flags and instruction events
  input wire logic CORE_READY_I,
  input wire logic UND_EXEC_I,
  input wire logic OVF_EXEC_I,
  input wire logic O_FLAG_I,
  input wire logic BRK_EXEC_I,
  input wire logic TRAP_EXEC_I,
  input wire logic [5:0] TRAP_NUM_I,
  input wire logic INSTR_DONE_I,
  input wire logic D_FLAG_I,
  input wire logic U_FLAG_I,
  input wire logic I_FLAG_I,
  input wire logic [2:0] IPL_I,
  input wire logic RETURN_I,
  input wire logic [19:0] NEXT_PC_I,
  input wire logic NEXT_PC_FIRST_I,
  // Special sources
  input wire logic NMI_N_I,
  input wire logic WDT_EXPIRE_I,
  input wire logic DEBUGGER_BREAK_IRQ_I,
  input wire logic ADDR_MATCH_EN_I,
  input wire logic [19:0] ADDR_MATCH_ADDR_I,
  // Maskable sources
  input wire logic [NUM_SRC-1:0] PERIPH_REQ_I,
  input wire logic [3*NUM_SRC-1:0] PRIO_I,
  input wire logic [KEY_WIDTH-1:0] KEY_INPUT_PIN_I,
  input wire logic KEY_BOTH_EDGES_I,
  input wire logic [5:0] EXT_IRQ_PIN_I,
  input wire logic [11:0] EXT_EDGE_SEL_I,
  input wire logic [19:0] VECTOR_TABLE_BASE_REG_I,
  // Vector read port
  output logic VEC_RD_O,
  output logic [19:0] VEC_RD_ADDR_O,
  input wire logic VEC_RD_ACK_I,
  input wire logic [31:0] VEC_RD_DATA_I,
  // Branch to routine
  output logic BRANCH_O,
  output logic [19:0] ROUTINE_ADDR_O,
  output isv_pkg::isv_src_type SRC_O,
  output logic [5:0] VEC_NUM_O,
  output logic U_CLEAR_O,
  output logic U_RESTORE_O,
  output logic U_RESTORE_VAL_O
);
  import isv_pkg::*;

  localparam int EXT_N = 6;

  if (NUM_SRC != 32 || KEY_WIDTH < 1 || NEST_DEPTH < 1) begin : g_chk
    $error("isv_ctrl needs NUM_SRC 32, KEY_WIDTH and NEST_DEPTH at least 1");
  end

  isv_state_type state_q;
  isv_src_type src_q;
  isv_src_type pick;
  logic reset_pend_q;
  logic und_pend_q;
  logic ovf_pend_q;
  logic brk_pend_q;
  logic trap_pend_q;
  logic [5:0] trap_num_q;
  logic nmi_pend_q;
  logic dbg_pend_q;
  logic wdt_pend_q;
  logic step_pend_q;
  logic amatch_pend_q;
  logic [NUM_SRC-1:0] pend_q;
  logic [NUM_SRC-1:0] pin_set;
  logic [5:0] num_q;
  logic [19:0] rd_addr_q;
  logic [19:0] routine_q;
  logic branch_q;
  logic u_clear_q;
  logic u_restore_q;
  logic u_restore_val_q;
  logic [NEST_DEPTH-1:0] u_stack_q;
  logic start;
  logic mask_hit;
  logic [4:0] mask_num;
  logic [2:0] best_lvl;
  logic [KEY_WIDTH-1:0] key_edge;
  logic [EXT_N-1:0] ext_edge;
  logic [EXT_N-1:0] ext_rise;
  logic [EXT_N-1:0] ext_fall;
  logic nmi_edge;

  // Key inputs: falling always, rising too when both edges selected
  isv_edge_sync #(
    .WIDTH(KEY_WIDTH)
  ) u_key_sync (
    .clk_i(MCLK_I),
    .reset_n_i(RESET_N_I),
    .pin_i(KEY_INPUT_PIN_I),
    .rise_en_i({KEY_WIDTH{KEY_BOTH_EDGES_I}}),
    .fall_en_i({KEY_WIDTH{1'b1}}),
    .level_o(),
    .edge_o(key_edge)
  );

  // Per-pin edge selection for the external interrupt pins
  for (genvar e = 0; e < EXT_N; e++) begin : g_ext
    assign ext_rise[e] = (EXT_EDGE_SEL_I[2*e +: 2] == `ISV_EDGE_RISE) ||
                         (EXT_EDGE_SEL_I[2*e +: 2] == `ISV_EDGE_BOTH);
    assign ext_fall[e] = (EXT_EDGE_SEL_I[2*e +: 2] == `ISV_EDGE_FALL) ||
                         (EXT_EDGE_SEL_I[2*e +: 2] == `ISV_EDGE_BOTH);
  end

  isv_edge_sync #(
    .WIDTH(EXT_N)
  ) u_ext_sync (
    .clk_i(MCLK_I),
    .reset_n_i(RESET_N_I),
    .pin_i(EXT_IRQ_PIN_I),
    .rise_en_i(ext_rise),
    .fall_en_i(ext_fall),
    .level_o(),
    .edge_o(ext_edge)
  );

  // Non-maskable pin; its fall to low raises one request
  isv_edge_sync #(
    .WIDTH(1)
  ) u_nmi_sync (
    .clk_i(MCLK_I),
    .reset_n_i(RESET_N_I),
    .pin_i(NMI_N_I),
    .rise_en_i(1'b0),
    .fall_en_i(1'b1),
    .level_o(),
    .edge_o(nmi_edge)
  );

  // Pin-driven requests folded onto their shared table numbers
  always_comb begin
    pin_set = '0;
    pin_set[`ISV_NUM_KEY] = |key_edge;
    pin_set[`ISV_NUM_EXT0] = ext_edge[0];
    pin_set[`ISV_NUM_EXT1] = ext_edge[1];
    pin_set[`ISV_NUM_EXT2] = ext_edge[2];
    pin_set[`ISV_NUM_EXT3] = ext_edge[3];
    pin_set[`ISV_NUM_EXT4] = ext_edge[4];
    pin_set[`ISV_NUM_EXT5] = ext_edge[5];
  end

  // Maskable pick: highest level above IPL, lowest number on ties
  always_comb begin
    mask_hit = 1'b0;
    mask_num = 5'h00;
    best_lvl = 3'h0;
    for (int n = 0; n < NUM_SRC; n++) begin
      if (pend_q[n] && PRIO_I[3*n +: 3] > IPL_I && (!mask_hit || PRIO_I[3*n +: 3] > best_lvl)) begin
        mask_hit = 1'b1;
        mask_num = 5'(n);
        best_lvl = PRIO_I[3*n +: 3];
      end
    end
    mask_hit = mask_hit && I_FLAG_I;
  end

  // Fixed order; every non-maskable source beats maskable ones
  always_comb begin
    if (reset_pend_q) begin
      pick = SRC_RESET;
    end else if (und_pend_q) begin
      pick = SRC_UND;
    end else if (ovf_pend_q) begin
      pick = SRC_OVF;
    end else if (brk_pend_q) begin
      pick = SRC_BRK;
    end else if (trap_pend_q) begin
      pick = SRC_TRAP;
    end else if (nmi_pend_q) begin
      pick = SRC_NMI;
    end else if (dbg_pend_q) begin
      pick = SRC_DBG;
    end else if (wdt_pend_q) begin
      pick = SRC_WDT;
    end else if (amatch_pend_q) begin
      pick = SRC_AMATCH;
    end else if (step_pend_q) begin
      pick = SRC_STEP;
    end else if (mask_hit) begin
      pick = SRC_PERIPH;
    end else begin
      pick = SRC_NONE;
    end
  end

  // Reset is served without waiting for the core
  assign start = (state_q == ST_IDLE) && (pick != SRC_NONE) && (CORE_READY_I || pick == SRC_RESET);

  // Instruction-triggered requests; a new event beats the clear on acceptance
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      und_pend_q <= 1'b0;
      ovf_pend_q <= 1'b0;
      brk_pend_q <= 1'b0;
      trap_pend_q <= 1'b0;
      trap_num_q <= 6'h00;
    end else begin
      und_pend_q <= UND_EXEC_I || (und_pend_q && !(start && pick == SRC_UND));
      ovf_pend_q <= (OVF_EXEC_I && O_FLAG_I) || (ovf_pend_q && !(start && pick == SRC_OVF));
      brk_pend_q <= BRK_EXEC_I || (brk_pend_q && !(start && pick == SRC_BRK));
      trap_pend_q <= TRAP_EXEC_I || (trap_pend_q && !(start && pick == SRC_TRAP));
      if (TRAP_EXEC_I) begin
        trap_num_q <= TRAP_NUM_I;
      end
    end
  end

  // Special non-maskable requests; reset request stands from reset onward
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      reset_pend_q <= 1'b1;
      nmi_pend_q <= 1'b0;
      dbg_pend_q <= 1'b0;
      wdt_pend_q <= 1'b0;
      step_pend_q <= 1'b0;
      amatch_pend_q <= 1'b0;
    end else begin
      reset_pend_q <= reset_pend_q && !(start && pick == SRC_RESET);
      nmi_pend_q <= nmi_edge || (nmi_pend_q && !(start && pick == SRC_NMI));
      dbg_pend_q <= DEBUGGER_BREAK_IRQ_I || (dbg_pend_q && !(start && pick == SRC_DBG));
      wdt_pend_q <= WDT_EXPIRE_I || (wdt_pend_q && !(start && pick == SRC_WDT));
      step_pend_q <= (INSTR_DONE_I && D_FLAG_I) || (step_pend_q && !(start && pick == SRC_STEP));
      // Only an instruction boundary can match, so mid-instruction bytes never fire
      amatch_pend_q <= (ADDR_MATCH_EN_I && NEXT_PC_FIRST_I && NEXT_PC_I == ADDR_MATCH_ADDR_I) ||
                       (amatch_pend_q && !(start && pick == SRC_AMATCH));
    end
  end

  // Maskable request latches; set beats the clear of the accepted one
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      pend_q <= '0;
    end else begin
      for (int n = 0; n < NUM_SRC; n++) begin
        pend_q[n] <= PERIPH_REQ_I[n] || pin_set[n] ||
                     (pend_q[n] && !(start && pick == SRC_PERIPH && mask_num == 5'(n)));
      end
    end
  end

  // Source and table number of the accepted request
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      src_q <= SRC_NONE;
      num_q <= 6'h00;
    end else if (start) begin
      src_q <= pick;
      num_q <= (pick == SRC_TRAP) ? trap_num_q : {1'b0, mask_num};
    end
  end

  // Sequencer: fetch entry, maybe relocate for break, then branch
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_q <= ST_IDLE;
      rd_addr_q <= 20'h00000;
      routine_q <= 20'h00000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_FETCH;
            if (pick == SRC_TRAP || pick == SRC_PERIPH) begin
              // Relocatable entry: base plus four times the number, within 256 bytes
              rd_addr_q <= VECTOR_TABLE_BASE_REG_I +
                           {12'h000, (pick == SRC_TRAP) ? trap_num_q : {1'b0, mask_num}, 2'b00};
            end else begin
              rd_addr_q <= vec_of(pick);
            end
          end
        end
        ST_FETCH: begin
          if (VEC_RD_ACK_I) begin
            if (src_q == SRC_BRK && VEC_RD_DATA_I[7:0] == `ISV_BRK_REDIRECT) begin
              state_q <= ST_RELOC;
              rd_addr_q <= VECTOR_TABLE_BASE_REG_I + {12'h000, `ISV_NUM_BRK, 2'b00};
            end else begin
              state_q <= ST_BRANCH;
              routine_q <= VEC_RD_DATA_I[19:0];
            end
          end
        end
        ST_RELOC: begin
          if (VEC_RD_ACK_I) begin
            state_q <= ST_BRANCH;
            routine_q <= VEC_RD_DATA_I[19:0];
          end
        end
        ST_BRANCH: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Fixed table entry of each non-maskable source other than trap, used as the read address
  function automatic logic [19:0] vec_of(input isv_src_type s);
    case (s)
      SRC_RESET: vec_of = `ISV_VEC_RESET;
      SRC_UND: vec_of = `ISV_VEC_UND;
      SRC_OVF: vec_of = `ISV_VEC_OVF;
      SRC_BRK: vec_of = `ISV_VEC_BRK;
      SRC_NMI: vec_of = `ISV_VEC_NMI;
      SRC_DBG: vec_of = `ISV_VEC_DBG;
      SRC_WDT: vec_of = `ISV_VEC_WDT;
      SRC_STEP: vec_of = `ISV_VEC_STEP;
      SRC_AMATCH: vec_of = `ISV_VEC_AMATCH;
      default: vec_of = 20'h00000;
    endcase
  endfunction

  // Branch strobe and stack-select handling, one pulse per acceptance except stack select on traps 32..63
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      branch_q <= 1'b0;
      u_clear_q <= 1'b0;
    end else begin
      branch_q <= (state_q == ST_FETCH || state_q == ST_RELOC) && VEC_RD_ACK_I &&
                  !(state_q == ST_FETCH && src_q == SRC_BRK && VEC_RD_DATA_I[7:0] == `ISV_BRK_REDIRECT);
      // Traps 32..63 keep the current stack pointer
      u_clear_q <= start && !(pick == SRC_TRAP && trap_num_q[5]);
    end
  end

  // Saved stack-select flags; nesting beyond the depth loses the oldest entry
  always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      u_stack_q <= '0;
      u_restore_q <= 1'b0;
      u_restore_val_q <= 1'b0;
    end else begin
      u_restore_q <= RETURN_I;
      if (RETURN_I) begin
        u_restore_val_q <= u_stack_q[0];
      end
      if (start) begin
        u_stack_q <= NEST_DEPTH'({u_stack_q, U_FLAG_I});
      end else if (RETURN_I) begin
        u_stack_q <= u_stack_q >> 1;
      end
    end
  end

  assign VEC_RD_O = (state_q == ST_FETCH) || (state_q == ST_RELOC);
  assign VEC_RD_ADDR_O = rd_addr_q;
  assign BRANCH_O = branch_q;
  assign ROUTINE_ADDR_O = routine_q;
  assign SRC_O = src_q;
  assign VEC_NUM_O = num_q;
  assign U_CLEAR_O = u_clear_q;
  assign U_RESTORE_O = u_restore_q;
  assign U_RESTORE_VAL_O = u_restore_val_q;
endmodule

// ### isv_checker.sv
module isv_checker (
  input wire logic MCLK_I,
  input wire logic RESET_N_I,
  input wire logic I_FLAG_I,
  input wire logic [19:0] VECTOR_TABLE_BASE_REG_I,
  input wire logic VEC_RD_O,
  input wire logic [19:0] VEC_RD_ADDR_O,
  input wire logic VEC_RD_ACK_I,
  input wire logic [31:0] VEC_RD_DATA_I,
  input wire logic BRANCH_O,
  input wire logic [19:0] ROUTINE_ADDR_O,
  input wire logic [3:0] SRC_O,
  input wire logic [5:0] VEC_NUM_O,
  input wire logic U_CLEAR_O
);
  import isv_pkg::*;
  logic [19:0] rel_off;
  // Offset into the relocatable table; only valid while a relocatable entry is read
  assign rel_off = VEC_RD_ADDR_O - VECTOR_TABLE_BASE_REG_I;
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  // Completed entry read
  sequence read_done_s;
    VEC_RD_O && VEC_RD_ACK_I;
  endsequence
  sequence brk_redirect_s;
    read_done_s ##0 (VEC_RD_ADDR_O == 20'hFFFE4 && VEC_RD_DATA_I[7:0] == 8'hFF);
  endsequence
  reset_vector_a: assert property (BRANCH_O && SRC_O == SRC_RESET |-> VEC_RD_ADDR_O == 20'hFFFFC)
    else $error("reset branch used a wrong entry");
  und_vector_a: assert property (BRANCH_O && SRC_O == SRC_UND |-> VEC_RD_ADDR_O == 20'hFFFDC)
    else $error("undefined opcode branch used a wrong entry");
  nmi_vector_a: assert property (BRANCH_O && SRC_O == SRC_NMI |-> VEC_RD_ADDR_O == 20'hFFFF8)
    else $error("pin interrupt branch used a wrong entry");
  wdt_vector_a: assert property (BRANCH_O && SRC_O == SRC_WDT |-> VEC_RD_ADDR_O == 20'hFFFF0)
    else $error("watchdog branch used a wrong entry");
  branch_after_ack_a: assert property (read_done_s ##0 VEC_RD_DATA_I[7:0] != 8'hFF
    |=> BRANCH_O && ROUTINE_ADDR_O == 20'($past(VEC_RD_DATA_I)))
    else $error("branch did not follow the entry read");
  brk_redirect_a: assert property (brk_redirect_s |=> !BRANCH_O ##[1:8] (BRANCH_O && SRC_O == SRC_BRK))
    else $error("break redirect did not relocate");
  trap_entry_a: assert property (BRANCH_O && SRC_O == SRC_TRAP |-> rel_off == {12'h0, VEC_NUM_O, 2'b00})
    else $error("trap branch used a wrong relocatable entry");
  trap_stack_a: assert property (U_CLEAR_O |-> rel_off[19:7] != 13'h1)
    else $error("stack select cleared for an upper trap");
  mask_gate_a: assert property (!I_FLAG_I [*8] |-> !(BRANCH_O && SRC_O == SRC_PERIPH))
    else $error("maskable branch taken while disabled");
endmodule

bind isv_ctrl isv_checker isv_checker_i (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .I_FLAG_I(I_FLAG_I),
  .VECTOR_TABLE_BASE_REG_I(VECTOR_TABLE_BASE_REG_I), .VEC_RD_O(VEC_RD_O), .VEC_RD_ADDR_O(VEC_RD_ADDR_O),
  .VEC_RD_ACK_I(VEC_RD_ACK_I), .VEC_RD_DATA_I(VEC_RD_DATA_I), .BRANCH_O(BRANCH_O),
  .ROUTINE_ADDR_O(ROUTINE_ADDR_O), .SRC_O(SRC_O), .VEC_NUM_O(VEC_NUM_O), .U_CLEAR_O(U_CLEAR_O));

// ### isv_vec_mem.sv
module isv_vec_mem (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic rd_i,
  input wire logic [19:0] addr_i,
  input wire logic redirect_i,
  input wire logic slow_i,
  output logic ack_o,
  output logic [31:0] data_o
);
  logic [1:0] wait_q;
  // Routine address is the entry address scrambled, never ending in FF
  function automatic logic [31:0] entry(input logic [19:0] a);
    if (redirect_i && a == 20'hFFFE4) return 32'h000000FF;
    return {12'hA5A, a ^ 20'h0F0F0};
  endfunction
  // Answers at once or after three waits; stale data is inverted so it cannot be reused
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_o <= 1'b0;
      wait_q <= 2'h0;
      data_o <= 32'h0;
    end else if (rd_i && !ack_o && (!slow_i || wait_q == 2'h3)) begin
      ack_o <= 1'b1;
      data_o <= entry(addr_i);
      wait_q <= 2'h0;
    end else begin
      ack_o <= 1'b0;
      data_o <= ~data_o;
      if (rd_i && !ack_o) wait_q <= wait_q + 2'h1;
    end
  end
endmodule

// ### interrupt_source_vectoring_bench.sv
module interrupt_source_vectoring_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import isv_pkg::*;
  logic MCLK_I, RESET_N_I, UND_EXEC_I, OVF_EXEC_I, O_FLAG_I, BRK_EXEC_I, TRAP_EXEC_I, INSTR_DONE_I, D_FLAG_I;
  logic I_FLAG_I, RETURN_I, NEXT_PC_FIRST_I, NMI_N_I, WDT_EXPIRE_I, DEBUGGER_BREAK_IRQ_I, ADDR_MATCH_EN_I;
  logic KEY_BOTH_EDGES_I, VEC_RD_O, VEC_RD_ACK_I, BRANCH_O, U_CLEAR_O, U_RESTORE_O, U_RESTORE_VAL_O;
  logic [5:0] TRAP_NUM_I, EXT_IRQ_PIN_I, VEC_NUM_O;
  logic [2:0] IPL_I;
  logic [19:0] NEXT_PC_I, VEC_RD_ADDR_O, ROUTINE_ADDR_O;
  logic [31:0] PERIPH_REQ_I, VEC_RD_DATA_I;
  logic [7:0] KEY_INPUT_PIN_I;
  logic [11:0] EXT_EDGE_SEL_I;
  logic [95:0] PRIO_I;
  isv_src_type SRC_O;
  logic redirect, slow, u_seen, r_seen;
  int n_fail = 0;
  int cmp_count = 0;
  int cycles = 0;
  localparam logic [19:0] BASE = 20'h40000;

  isv_ctrl isv_ctrl_i (.MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .CORE_READY_I(1'b1), .UND_EXEC_I(UND_EXEC_I),
    .OVF_EXEC_I(OVF_EXEC_I), .O_FLAG_I(O_FLAG_I), .BRK_EXEC_I(BRK_EXEC_I), .TRAP_EXEC_I(TRAP_EXEC_I),
    .TRAP_NUM_I(TRAP_NUM_I), .INSTR_DONE_I(INSTR_DONE_I), .D_FLAG_I(D_FLAG_I), .U_FLAG_I(1'b1),
    .I_FLAG_I(I_FLAG_I), .IPL_I(IPL_I), .RETURN_I(RETURN_I), .NEXT_PC_I(NEXT_PC_I),
    .NEXT_PC_FIRST_I(NEXT_PC_FIRST_I), .NMI_N_I(NMI_N_I), .WDT_EXPIRE_I(WDT_EXPIRE_I),
    .DEBUGGER_BREAK_IRQ_I(DEBUGGER_BREAK_IRQ_I), .ADDR_MATCH_EN_I(ADDR_MATCH_EN_I),
    .ADDR_MATCH_ADDR_I(20'h01234), .PERIPH_REQ_I(PERIPH_REQ_I), .PRIO_I(PRIO_I),
    .KEY_INPUT_PIN_I(KEY_INPUT_PIN_I), .KEY_BOTH_EDGES_I(KEY_BOTH_EDGES_I), .EXT_IRQ_PIN_I(EXT_IRQ_PIN_I),
    .EXT_EDGE_SEL_I(EXT_EDGE_SEL_I), .VECTOR_TABLE_BASE_REG_I(BASE), .VEC_RD_O(VEC_RD_O),
    .VEC_RD_ADDR_O(VEC_RD_ADDR_O), .VEC_RD_ACK_I(VEC_RD_ACK_I), .VEC_RD_DATA_I(VEC_RD_DATA_I),
    .BRANCH_O(BRANCH_O), .ROUTINE_ADDR_O(ROUTINE_ADDR_O), .SRC_O(SRC_O), .VEC_NUM_O(VEC_NUM_O),
    .U_CLEAR_O(U_CLEAR_O), .U_RESTORE_O(U_RESTORE_O), .U_RESTORE_VAL_O(U_RESTORE_VAL_O));
  isv_vec_mem isv_vec_mem_i (.clk_i(MCLK_I), .reset_n_i(RESET_N_I), .rd_i(VEC_RD_O), .addr_i(VEC_RD_ADDR_O),
    .redirect_i(redirect), .slow_i(slow), .ack_o(VEC_RD_ACK_I), .data_o(VEC_RD_DATA_I));

  initial begin
    MCLK_I = 1'b0;
    forever #4 MCLK_I = ~MCLK_I;
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge MCLK_I) begin
    cycles++;
    if (U_CLEAR_O === 1'b1) u_seen = 1'b1;
    if (U_RESTORE_O === 1'b1 && U_RESTORE_VAL_O === 1'b1) r_seen = 1'b1;
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Scrambled routine address the memory model stores for an entry
  function automatic logic [19:0] v(input logic [19:0] a);
    return a ^ 20'h0F0F0;
  endfunction
  // Request pulse of one cycle (three for the NMI pin), driven between clock edges
  task automatic fire(input int code, input logic [5:0] num);
    @(negedge MCLK_I);
    case (code)
      0: UND_EXEC_I = 1'b1;
      1: OVF_EXEC_I = 1'b1;
      2: BRK_EXEC_I = 1'b1;
      3: TRAP_EXEC_I = 1'b1;
      4: WDT_EXPIRE_I = 1'b1;
      5: DEBUGGER_BREAK_IRQ_I = 1'b1;
      6: INSTR_DONE_I = 1'b1;
      7: NMI_N_I = 1'b0;
      8: RETURN_I = 1'b1;
      9: PERIPH_REQ_I[num[4:0]] = 1'b1;
      default: NEXT_PC_FIRST_I = 1'b1;
    endcase
    TRAP_NUM_I = num;
    if (code == 7) repeat (2) @(negedge MCLK_I); // Pin held low past the glitch filter
    @(negedge MCLK_I);
    {UND_EXEC_I, OVF_EXEC_I, BRK_EXEC_I, TRAP_EXEC_I, WDT_EXPIRE_I, DEBUGGER_BREAK_IRQ_I} = 6'h0;
    {INSTR_DONE_I, RETURN_I, NEXT_PC_FIRST_I, NMI_N_I} = 4'h1;
    PERIPH_REQ_I = 32'h0;
  endtask
  task automatic expect_branch(input isv_src_type src, input logic [19:0] addr);
    int n;
    n = 0;
    while (BRANCH_O !== 1'b1 && n < 40) begin
      @(negedge MCLK_I);
      n++;
    end
    check("branch", 20'h1, {19'h0, BRANCH_O});
    check("source", {16'h0, src}, {16'h0, SRC_O});
    check("routine", addr, ROUTINE_ADDR_O);
    @(negedge MCLK_I);
  endtask
  task automatic expect_none(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge MCLK_I);
      seen = seen | (BRANCH_O !== 1'b0);
    end
    check("idle", 20'h0, {19'h0, seen});
  endtask

  initial begin
    int codes[6] = '{0, 1, 2, 4, 5, 7};
    isv_src_type srcs[6] = '{SRC_UND, SRC_OVF, SRC_BRK, SRC_WDT, SRC_DBG, SRC_NMI};
    logic [19:0] vecs[6] = '{20'hFFFDC, 20'hFFFE0, 20'hFFFE4, 20'hFFFF0, 20'hFFFF4, 20'hFFFF8};
    logic [5:0] nums[4] = '{6'd5, 6'd31, 6'd32, 6'd63};
    {RESET_N_I, UND_EXEC_I, OVF_EXEC_I, BRK_EXEC_I, TRAP_EXEC_I, INSTR_DONE_I, D_FLAG_I, I_FLAG_I} = 8'h0;
    {RETURN_I, NEXT_PC_FIRST_I, WDT_EXPIRE_I, DEBUGGER_BREAK_IRQ_I, ADDR_MATCH_EN_I, KEY_BOTH_EDGES_I} = 6'h0;
    {redirect, slow, u_seen, r_seen} = 4'h0;
    {NMI_N_I, O_FLAG_I} = 2'h3;
    TRAP_NUM_I = 6'h0;
    IPL_I = 3'h0;
    NEXT_PC_I = 20'h0;
    PERIPH_REQ_I = 32'h0;
    KEY_INPUT_PIN_I = 8'hFF;
    PRIO_I = {32{3'h3}};
    EXT_IRQ_PIN_I = 6'h3D;
    EXT_EDGE_SEL_I = 12'hFF4;
    repeat (8) @(posedge MCLK_I);
    @(negedge MCLK_I);
    RESET_N_I = 1'b1;
    expect_branch(SRC_RESET, v(20'hFFFFC));
    // Global enable stays off: none of these may be held back
    for (int i = 0; i < 6; i++) begin
      fire(codes[i], 6'h0);
      expect_branch(srcs[i], v(vecs[i]));
    end
    O_FLAG_I = 1'b0;
    fire(1, 6'h0);
    expect_none(20);
    redirect = 1'b1;
    fire(2, 6'h0);
    expect_branch(SRC_BRK, v(BASE));
    redirect = 1'b0;
    slow = 1'b1;
    foreach (nums[i]) begin
      u_seen = 1'b0;
      fire(3, nums[i]);
      expect_branch(SRC_TRAP, v(BASE + {12'h0, nums[i], 2'b00}));
      check("trap stack select", {19'h0, nums[i] < 6'd32}, {19'h0, u_seen});
    end
    fire(8, 6'h0);
    repeat (4) @(negedge MCLK_I);
    check("stack restore", 20'h1, {19'h0, r_seen});
    slow = 1'b0;
    fire(9, 6'd14);
    expect_none(20);
    I_FLAG_I = 1'b1;
    IPL_I = 3'h3;
    expect_none(20);
    IPL_I = 3'h0;
    expect_branch(SRC_PERIPH, v(BASE + 20'd56));
    check("vector number", 20'd14, {14'h0, VEC_NUM_O});
    EXT_IRQ_PIN_I[0] = 1'b0;
    expect_branch(SRC_PERIPH, v(BASE + 20'd116));
    EXT_IRQ_PIN_I[1] = 1'b1;
    expect_branch(SRC_PERIPH, v(BASE + 20'd120));
    KEY_INPUT_PIN_I[2] = 1'b0;
    expect_branch(SRC_PERIPH, v(BASE + 20'd52));
    KEY_BOTH_EDGES_I = 1'b1;
    KEY_INPUT_PIN_I[2] = 1'b1;
    expect_branch(SRC_PERIPH, v(BASE + 20'd52));
    D_FLAG_I = 1'b1;
    fire(6, 6'h0);
    expect_branch(SRC_STEP, v(20'hFFFEC));
    D_FLAG_I = 1'b0;
    ADDR_MATCH_EN_I = 1'b1;
    NEXT_PC_I = 20'h01234;
    expect_none(10);
    fire(10, 6'h0);
    expect_branch(SRC_AMATCH, v(20'hFFFE8));
    ADDR_MATCH_EN_I = 1'b0;
    @(negedge MCLK_I);
    WDT_EXPIRE_I = 1'b1;
    PERIPH_REQ_I[5] = 1'b1;
    PERIPH_REQ_I[20] = 1'b1;
    PRIO_I[62:60] = 3'h5;
    @(negedge MCLK_I);
    WDT_EXPIRE_I = 1'b0;
    PERIPH_REQ_I = 32'h0;
    expect_branch(SRC_WDT, v(20'hFFFF0));
    expect_branch(SRC_PERIPH, v(BASE + 20'd80));
    expect_branch(SRC_PERIPH, v(BASE + 20'd20));
    wrap_up();
  end
endmodule
